//--- hdl/lsw_compare.v
`timescale 1ns/100ps
`include "lsw_defs.vh"

// What this block does
// - output on while watch lies in an on region; two regions per setting
// - limits and watch value compare as signed two's complement
// - lower below upper: on for lower <= watch < upper
// - lower above upper: region wraps, on at or above lower or below upper
// - equal limits: region never on
// - evaluate and drive outputs only while ready complete is set
// - keep option on: non-Y outputs hold through ready fall
// - Y-type outputs always clear on ready fall
// - word-device limits load on ready rise, then once per cycle
// - up to 64 settings, may share watch data and output point
// - each used output is the OR of all hitting regions and settings; outputs with no enabled setting hold unless their 16-bit group is in batch mode
// - enabled forced-off bit holds the point off
// - enabled forced-on bit drives the point on, beating forced-off
// - per-setting compensation time accepted, clamped to signed microsecond range
// - ring-counter wrap value accepted up to the width's maximum
// - watch data may be 16-bit or 32-bit signed per setting
// - batch mode writes 16-bit groups, unused bits held off
module lsw_compare #(
  parameter NUM_SET = `LSW_NUM_SET,
  parameter NUM_OUT = `LSW_NUM_OUT,
  parameter IDX_W = `LSW_IDX_W
) (
  input wire clk,
  input wire reset_n,
  input wire controller_ready_flag,
  input wire cycle_tick,
  input wire keep_on_ready_drop,
  input wire [NUM_OUT-1:0] y_type,
  input wire [NUM_OUT/16-1:0] batch_en,
  input wire [NUM_OUT-1:0] force_off_en,
  input wire [NUM_OUT-1:0] force_off_bit,
  input wire [NUM_OUT-1:0] force_on_en,
  input wire [NUM_OUT-1:0] force_on_bit,
  input wire [NUM_SET-1:0] set_en,
  input wire [NUM_SET*IDX_W-1:0] set_target,
  input wire [NUM_SET*32-1:0] watch_val,
  input wire [NUM_SET-1:0] watch_wide,
  input wire [NUM_SET*2-1:0] watch_src,
  input wire [NUM_SET*32-1:0] ring_val,
  input wire [NUM_SET*2-1:0] region_en,
  input wire [NUM_SET-1:0] limit_from_word,
  input wire [NUM_SET*32-1:0] lo1_in,
  input wire [NUM_SET*32-1:0] hi1_in,
  input wire [NUM_SET*32-1:0] lo2_in,
  input wire [NUM_SET*32-1:0] hi2_in,
  input wire [NUM_SET*32-1:0] comp_time_in,
  output reg [NUM_OUT-1:0] point_out_reg,
  output reg ready_complete_flag_reg,
  output reg [NUM_SET*32-1:0] comp_time_reg
);
  reg ready_meta_reg;
  reg ready_sync_reg;
  reg ready_prev_reg;
  reg [NUM_SET*32-1:0] lo1_reg;
  reg [NUM_SET*32-1:0] hi1_reg;
  reg [NUM_SET*32-1:0] lo2_reg;
  reg [NUM_SET*32-1:0] hi2_reg;
  reg [NUM_SET*32-1:0] comp_time_next;
  reg [NUM_OUT-1:0] or_next;
  reg [NUM_OUT-1:0] used_next;
  reg [NUM_OUT-1:0] point_out_next;
  wire [NUM_SET-1:0] hit;
  wire ready_rise;
  wire ready_fall;
  integer s;
  integer o;

  assign ready_rise = ready_sync_reg && !ready_prev_reg;
  assign ready_fall = !ready_sync_reg && ready_prev_reg;

  genvar g;
  generate
    for (g = 0; g < NUM_SET; g = g + 1) begin : gen_set
      wire sel_word;
      assign sel_word = limit_from_word[g];
      lsw_setting u_set (
        .watch(watch_val[g*32 +: 32]),
        .wide(watch_wide[g]),
        .src(watch_src[g*2 +: 2]),
        .ring_val(ring_val[g*32 +: 32]),
        .region_en(set_en[g] ? region_en[g*2 +: 2] : 2'h0),
        .lo1(sel_word ? lo1_reg[g*32 +: 32] : lo1_in[g*32 +: 32]),
        .hi1(sel_word ? hi1_reg[g*32 +: 32] : hi1_in[g*32 +: 32]),
        .lo2(sel_word ? lo2_reg[g*32 +: 32] : lo2_in[g*32 +: 32]),
        .hi2(sel_word ? hi2_reg[g*32 +: 32] : hi2_in[g*32 +: 32]),
        .hit(hit[g])
      );
    end
  endgenerate

  // ready flag comes from another controller, so it is synchronised
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_meta_reg <= 1'b0;
      ready_sync_reg <= 1'b0;
      ready_prev_reg <= 1'b0;
      ready_complete_flag_reg <= 1'b0;
    end else begin
      ready_meta_reg <= controller_ready_flag;
      ready_sync_reg <= ready_meta_reg;
      ready_prev_reg <= ready_sync_reg;
      if (ready_rise) begin
        ready_complete_flag_reg <= 1'b1;
      end else if (ready_fall) begin
        ready_complete_flag_reg <= 1'b0;
      end
    end
  end

  // word-device limits: first load on ready rise, refreshed every cycle tick while ready complete is set
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lo1_reg <= {NUM_SET*32{1'b0}};
      hi1_reg <= {NUM_SET*32{1'b0}};
      lo2_reg <= {NUM_SET*32{1'b0}};
      hi2_reg <= {NUM_SET*32{1'b0}};
    end else if (ready_rise || (ready_complete_flag_reg && cycle_tick)) begin
      lo1_reg <= lo1_in;
      hi1_reg <= hi1_in;
      lo2_reg <= lo2_in;
      hi2_reg <= hi2_in;
    end
  end

  // compensation clamp; the value is handed on, the timing shift itself
  // needs axis speed which this block does not see
  always @* begin
    comp_time_next = comp_time_in;
    for (s = 0; s < NUM_SET; s = s + 1) begin
      if ($signed(comp_time_in[s*32 +: 32]) > $signed(`LSW_COMP_MAX)) begin
        comp_time_next[s*32 +: 32] = `LSW_COMP_MAX;
      end else if ($signed(comp_time_in[s*32 +: 32]) < $signed(`LSW_COMP_MIN)) begin
        comp_time_next[s*32 +: 32] = `LSW_COMP_MIN;
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      comp_time_reg <= {NUM_SET*32{1'b0}};
    end else begin
      comp_time_reg <= comp_time_next;
    end
  end

  // OR of every setting aimed at each point, 64x64 flat loop
  always @* begin
    or_next = {NUM_OUT{1'b0}};
    used_next = {NUM_OUT{1'b0}};
    for (o = 0; o < NUM_OUT; o = o + 1) begin
      for (s = 0; s < NUM_SET; s = s + 1) begin
        if (set_en[s] && (set_target[s*IDX_W +: IDX_W] == o[IDX_W-1:0])) begin
          used_next[o] = 1'b1;
          if (hit[s]) begin
            or_next[o] = 1'b1;
          end
        end
      end
    end
  end

  // order: region OR or batch/unused handling, then forced-off, then forced-on
  always @* begin
    point_out_next = point_out_reg;
    for (o = 0; o < NUM_OUT; o = o + 1) begin
      if (used_next[o]) begin
        point_out_next[o] = or_next[o];
      end else if (batch_en[o/16]) begin
        point_out_next[o] = 1'b0;
      end
      if (force_off_en[o] && force_off_bit[o]) begin
        point_out_next[o] = 1'b0;
      end
      if (force_on_en[o] && force_on_bit[o]) begin
        point_out_next[o] = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      point_out_reg <= {NUM_OUT{1'b0}};
    end else if (ready_fall) begin
      if (keep_on_ready_drop) begin
        point_out_reg <= point_out_reg & ~y_type;
      end else begin
        point_out_reg <= {NUM_OUT{1'b0}};
      end
    end else if (ready_complete_flag_reg && cycle_tick) begin
      point_out_reg <= point_out_next;
    end
  end
endmodule

//--- hdl/lsw_defs.vh
`ifndef LSW_DEFS_VH
`define LSW_DEFS_VH

// setting and output counts
`define LSW_NUM_SET 64
`define LSW_NUM_OUT 64
`define LSW_IDX_W 6
`define LSW_GROUP_W 16

// compensation time clamp, microseconds, two's complement
`define LSW_COMP_MAX 32'h004c4b40
`define LSW_COMP_MIN 32'hffb3b4c0

// ring counter wrap value limits
`define LSW_RING_MIN 32'h00000001
`define LSW_RING_MAX16 32'h00007fff
`define LSW_RING_MAX32 32'h7fffffff

// watch data source codes
`define LSW_SRC_MOTION 2'h0
`define LSW_SRC_WORD 2'h1
`define LSW_SRC_RING 2'h2

`endif

//--- hdl/lsw_setting.v
`timescale 1ns/100ps
`include "lsw_defs.vh"

module lsw_setting (
  input wire [31:0] watch,
  input wire wide,
  input wire [1:0] src,
  input wire [31:0] ring_val,
  input wire [1:0] region_en,
  input wire [31:0] lo1,
  input wire [31:0] hi1,
  input wire [31:0] lo2,
  input wire [31:0] hi2,
  output wire hit
);
  wire signed [31:0] w_s;
  wire signed [31:0] lo1_s;
  wire signed [31:0] hi1_s;
  wire signed [31:0] lo2_s;
  wire signed [31:0] hi2_s;
  wire ring_ok;
  wire r1;
  wire r2;

  // narrow data compares on the sign-extended low half
  assign w_s = wide ? watch : {{16{watch[15]}}, watch[15:0]};
  assign lo1_s = wide ? lo1 : {{16{lo1[15]}}, lo1[15:0]};
  assign hi1_s = wide ? hi1 : {{16{hi1[15]}}, hi1[15:0]};
  assign lo2_s = wide ? lo2 : {{16{lo2[15]}}, lo2[15:0]};
  assign hi2_s = wide ? hi2 : {{16{hi2[15]}}, hi2[15:0]};

  // a wrap value out of range disables the setting rather than guessing
  assign ring_ok = (src != `LSW_SRC_RING) ||
    (($signed(ring_val) >= $signed(`LSW_RING_MIN)) &&
     ($signed(ring_val) <= $signed(wide ? `LSW_RING_MAX32 : `LSW_RING_MAX16)));

  function region;
    input signed [31:0] w;
    input signed [31:0] lo;
    input signed [31:0] hi;
    begin
      if (lo < hi) begin
        region = (w >= lo) && (w < hi);
      end else if (lo > hi) begin
        region = (w >= lo) || (w < hi);
      end else begin
        region = 1'b0;
      end
    end
  endfunction

  assign r1 = region_en[0] && region(w_s, lo1_s, hi1_s);
  assign r2 = region_en[1] && region(w_s, lo2_s, hi2_s);
  assign hit = ring_ok && (r1 || r2);
endmodule

//--- tb/lsw_compare_properties.sv
`timescale 1ns/100ps
module lsw_compare_properties #(parameter NUM_OUT = 64) (
  input wire clk,
  input wire reset_n,
  input wire controller_ready_flag,
  input wire cycle_tick,
  input wire keep_on_ready_drop,
  input wire [NUM_OUT-1:0] y_type,
  input wire [NUM_OUT-1:0] force_off_en,
  input wire [NUM_OUT-1:0] force_off_bit,
  input wire [NUM_OUT-1:0] force_on_en,
  input wire [NUM_OUT-1:0] force_on_bit,
  input wire [NUM_OUT-1:0] point_out_reg,
  input wire ready_complete_flag_reg
);
  reg [NUM_OUT-1:0] fon_q;
  reg [NUM_OUT-1:0] foff_q;
  // masks as seen at the tick edge, forced on wins
  always @(posedge clk) begin
    fon_q <= force_on_en & force_on_bit;
    foff_q <= force_off_en & force_off_bit & ~(force_on_en & force_on_bit);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_RDY_UP: assert property (controller_ready_flag [*4] |-> ready_complete_flag_reg)
    else $error("ready complete not set");
  AST_RDY_DN: assert property (!controller_ready_flag [*4] |-> !ready_complete_flag_reg)
    else $error("ready complete not cleared");
  AST_UPD: assert property ($changed(point_out_reg) |->
    ($past(cycle_tick) && $past(ready_complete_flag_reg)) || $fell(ready_complete_flag_reg))
    else $error("outputs moved without tick");
  AST_CLR_ALL: assert property ($fell(ready_complete_flag_reg) && !keep_on_ready_drop
    |-> point_out_reg == 0) else $error("outputs not cleared");
  AST_CLR_Y: assert property ($fell(ready_complete_flag_reg)
    |-> (point_out_reg & y_type) == 0) else $error("y outputs not cleared");
  AST_KEEP: assert property ($fell(ready_complete_flag_reg) && keep_on_ready_drop
    |-> (point_out_reg & ~y_type) == ($past(point_out_reg) & ~y_type))
    else $error("kept outputs changed");
  AST_FON: assert property ($past(cycle_tick) && $past(ready_complete_flag_reg)
    && ready_complete_flag_reg |-> (point_out_reg & fon_q) == fon_q)
    else $error("forced on missing");
  AST_FOFF: assert property ($past(cycle_tick) && $past(ready_complete_flag_reg)
    && ready_complete_flag_reg |-> (point_out_reg & foff_q) == 0)
    else $error("forced off missing");
  cover property ($rose(ready_complete_flag_reg));
  cover property (cycle_tick && ready_complete_flag_reg);
  cover property ($fell(ready_complete_flag_reg) && keep_on_ready_drop);
endmodule
bind lsw_compare lsw_compare_properties #(.NUM_OUT(NUM_OUT)) chk (.clk(clk),
  .reset_n(reset_n), .controller_ready_flag(controller_ready_flag), .cycle_tick(cycle_tick),
  .keep_on_ready_drop(keep_on_ready_drop), .y_type(y_type), .force_off_en(force_off_en),
  .force_off_bit(force_off_bit), .force_on_en(force_on_en), .force_on_bit(force_on_bit),
  .point_out_reg(point_out_reg), .ready_complete_flag_reg(ready_complete_flag_reg));

//--- tb/lsw_compare_tb.sv
`timescale 1ns/100ps
module lsw_compare_tb;
  typedef struct {logic [31:0] w, a, b, c, d; logic wd, e;} lsw_row_t;
  reg clk = 0, reset_n = 0, rdy = 0, tick = 0, keep = 0;
  reg [15:0] ytp = 16'h0020, fofe = 0, fofb = 0, fone = 0, fonb = 0, po;
  reg [1:0] sen = 2'h1, ww = 2'h3;
  reg [3:0] ren = 4'hf;
  reg [7:0] tgt = 8'h50;
  reg [63:0] wv = 0, l1 = 0, h1 = 0, l2 = 0, h2 = 0, ct = 0, cto;
  reg rc, bat = 0;
  reg [1:0] lfw = 2'h0;
  reg [3:0] src = 4'h0;
  reg [63:0] rv = 64'h0;
  integer num_errors = 0, total_checks = 0, cyc = 0, i;
  lsw_row_t rows[9] = '{
    '{32'hfffffffb, 32'hfffffffb, 32'h3, 32'h0, 32'h0, 1'b1, 1'b1},
    '{32'h3, 32'hfffffffb, 32'h3, 32'h0, 32'h0, 1'b1, 1'b0},
    '{32'ha, 32'ha, 32'hfffffff6, 32'h0, 32'h0, 1'b1, 1'b1},
    '{32'hfffffff5, 32'ha, 32'hfffffff6, 32'h0, 32'h0, 1'b1, 1'b1},
    '{32'h0, 32'ha, 32'hfffffff6, 32'h0, 32'h0, 1'b1, 1'b0},
    '{32'h5, 32'h5, 32'h5, 32'h0, 32'h0, 1'b1, 1'b0},
    '{32'h0, 32'hffffffff, 32'h1, 32'h0, 32'h0, 1'b1, 1'b1},
    '{32'h7, 32'h5, 32'h5, 32'h0, 32'h8, 1'b1, 1'b1},
    '{32'h0000fffe, 32'hfffffffb, 32'h3, 32'h0, 32'h0, 1'b0, 1'b1}};
  // latched word limits lag the inputs by one tick
  lsw_compare #(.NUM_SET(2), .NUM_OUT(16), .IDX_W(4)) uut (.clk(clk), .reset_n(reset_n),
    .controller_ready_flag(rdy), .cycle_tick(tick), .keep_on_ready_drop(keep), .y_type(ytp),
    .batch_en(bat), .force_off_en(fofe), .force_off_bit(fofb), .force_on_en(fone),
    .force_on_bit(fonb), .set_en(sen), .set_target(tgt), .watch_val(wv), .watch_wide(ww),
    .watch_src(src), .ring_val(rv), .region_en(ren), .limit_from_word(lfw),
    .lo1_in(l1), .hi1_in(h1), .lo2_in(l2), .hi2_in(h2), .comp_time_in(ct),
    .point_out_reg(po), .ready_complete_flag_reg(rc), .comp_time_reg(cto));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      num_errors = num_errors + 1;
      end_sim;
    end
  end
  task chk(input [63:0] s, input [63:0] e, input string n);
    total_checks = total_checks + 1;
    if (s !== e) begin
      num_errors = num_errors + 1;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task tk;
    @(posedge clk) #1 tick = 1;
    @(posedge clk) #1 tick = 0;
  endtask
  task rdy_set(input v);
    rdy = v;
    repeat (4) @(posedge clk);
    #1 chk(rc, v, "ready complete");
  endtask
  task end_sim;
    if (num_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 reset_n = 1;
    chk({rc, po}, 0, "reset");
    rdy_set(1);
    ct = {32'h80000000, 32'h7fffffff};
    @(posedge clk) #1 chk(cto, {32'hffb3b4c0, 32'h004c4b40}, "clamp");
    for (i = 0; i < 9; i = i + 1) begin
      {wv[31:0], l1[31:0], h1[31:0], l2[31:0], h2[31:0]} =
        {rows[i].w, rows[i].a, rows[i].b, rows[i].c, rows[i].d};
      ww[0] = rows[i].wd;
      tk;
      chk(po[0], rows[i].e, "region");
    end
    sen = 2'h3; wv = 0; ww = 2'h3; l1 = {2{32'hffffffff}}; h1 = {2{32'h1}}; l2 = 0; h2 = 0;
    fofe = 16'h5; fofb = 16'h5; fone = 16'h4; fonb = 16'h4;
    tk;
    chk(po, 16'h0024, "forced");
    keep = 1;
    rdy_set(0);
    chk(po, 16'h0004, "keep");
    tk;
    chk(po, 16'h0004, "idle tick");
    rdy_set(1);
    keep = 0;
    tk;
    chk(po, 16'h0024, "retick");
    fone = 16'hc; fonb = 16'hc;
    tk;
    chk(po, 16'h002c, "force unused");
    fone = 16'h4; fonb = 16'h4;
    tk;
    chk(po, 16'h002c, "unused hold");
    bat = 1;
    tk;
    chk(po, 16'h0024, "batch clear");
    bat = 0; lfw = 2'h3; h1 = 0;
    tk;
    chk(po, 16'h0024, "word old");
    tk;
    chk(po, 16'h0004, "word new");
    lfw = 2'h0; h1 = {2{32'h1}}; src = 4'h8;
    tk;
    chk(po, 16'h0004, "ring bad");
    rv = {32'h7fffffff, 32'h0};
    tk;
    chk(po, 16'h0024, "ring ok");
    rdy_set(0);
    chk(po, 16'h0, "drop");
    end_sim;
  end
endmodule
